/* hdl/udp_read_regs.vh */
// Constants for the register-read command parser and its APB registers
`ifndef UDP_READ_REGS_VH
`define UDP_READ_REGS_VH

// Byte offsets inside the 64-byte command header
`define OFS_MARKER     6'h00
`define OFS_VERSION    6'h02
`define OFS_CMD        6'h03
`define OFS_FLAGS      6'h06
`define OFS_COUNT      6'h08
`define OFS_ADDR_HI    6'h0C
`define OFS_ADDR_LO    6'h0D
`define OFS_FAMILY     6'h10
`define OFS_RADDR      6'h11
`define OFS_RPORT      6'h15
`define OFS_CRC_FIRST  6'h02
`define OFS_CRC_LAST   6'h3D
`define OFS_HCRC       6'h3E
`define OFS_LAST       6'h3F
`define RESP_DATA_OFS  8'h40

// Field values
`define START_MARKER   16'hA1EC
`define PROTO_REV      8'h03
`define CMD_READ       8'h03
`define FAMILY_V4      8'h04
`define CRC_INIT       16'h0000
`define CRC_POLY       16'h1021
`define FLAG_SKIP_BIT  0

// Factory network settings
`define FACTORY_ADDR   32'hC0A8000A
`define FACTORY_MASK   32'hFFFFFF00
`define FACTORY_PORT   16'h2713

// APB register byte addresses
`define REG_CTRL       12'h000
`define REG_STATUS     12'h004
`define REG_ACCEPTS    12'h008
`define REG_DROPS      12'h00C
`define REG_NET_ADDR   12'h010
`define REG_NET_MASK   12'h014
`define REG_NET_PORT   12'h018
`define REG_ACT_ADDR   12'h01C
`define REG_ACT_MASK   12'h020
`define REG_ACT_PORT   12'h024

// Control bits
`define CTRL_ENABLE    0
`define CTRL_APPLY     1
`define CTRL_RESET     1'b1

// Net settings select codes
`define NET_SEL_ADDR   2'h0
`define NET_SEL_MASK   2'h1
`define NET_SEL_PORT   2'h2

`endif

/* hdl/header_crc16.v */
// Byte-serial CCITT CRC16 accumulator, MSB first
`include "udp_read_regs.vh"

module header_crc16 (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        clear,
  input  wire        en,
  input  wire [7:0]  data,
  output reg  [15:0] crc_q
);

  function [15:0] crc_byte;
    input [15:0] crc_in;
    input [7:0]  d;
    reg   [15:0] c;
    integer      i;
    begin
      c = crc_in;
      for (i = 7; i >= 0; i = i - 1) begin
        if (c[15] ^ d[i])
          c = {c[14:0], 1'b0} ^ `CRC_POLY;
        else
          c = {c[14:0], 1'b0};
      end
      crc_byte = c;
    end
  endfunction

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      crc_q <= `CRC_INIT;
    else if (clear)
      crc_q <= `CRC_INIT;
    else if (en)
      crc_q <= crc_byte(crc_q, data);
  end

endmodule // header_crc16

/* hdl/net_settings_regs.v */
// Pending and active network settings; pending copies in on apply only
`include "udp_read_regs.vh"

module net_settings_regs (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        wr_en,
  input  wire [1:0]  wr_sel,
  input  wire [31:0] wdata,
  input  wire        apply,
  output reg  [31:0] pend_addr_q,
  output reg  [31:0] pend_mask_q,
  output reg  [15:0] pend_port_q,
  output reg  [31:0] act_addr_q,
  output reg  [31:0] act_mask_q,
  output reg  [15:0] act_port_q
);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_addr_q <= `FACTORY_ADDR;
      pend_mask_q <= `FACTORY_MASK;
      pend_port_q <= `FACTORY_PORT;
    end else if (wr_en) begin
      if (wr_sel == `NET_SEL_ADDR)
        pend_addr_q <= wdata;
      else if (wr_sel == `NET_SEL_MASK)
        pend_mask_q <= wdata;
      else if (wr_sel == `NET_SEL_PORT)
        pend_port_q <= wdata[15:0];
    end
  end

  // Writes never reach the live match logic until a device reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_addr_q <= `FACTORY_ADDR;
      act_mask_q <= `FACTORY_MASK;
      act_port_q <= `FACTORY_PORT;
    end else if (apply) begin
      act_addr_q <= pend_addr_q;
      act_mask_q <= pend_mask_q;
      act_port_q <= pend_port_q;
    end
  end

endmodule // net_settings_regs

/* hdl/udp_register_read_parser.v */
// Register-read command header parser with APB control registers
`include "udp_read_regs.vh"

module udp_register_read_parser (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_valid,
  input  wire        rx_sof,
  input  wire [7:0]  rx_data,
  input  wire [31:0] rx_src_addr,
  input  wire [15:0] rx_src_port,
  input  wire [31:0] rx_dst_addr,
  input  wire [15:0] rx_dst_port,
  output reg         rx_ready,
  output reg         rd_valid,
  input  wire        rd_ready,
  output reg  [15:0] rd_addr,
  output reg  [31:0] rd_count,
  output reg  [31:0] rd_words,
  output reg         rd_skip_data_crc,
  output reg  [31:0] rd_reply_addr,
  output reg  [15:0] rd_reply_port,
  output reg  [7:0]  rd_data_ofs
);

  function in_span;
    input [5:0] idx;
    input [5:0] lo;
    input [5:0] hi;
    begin
      in_span = (idx >= lo) && (idx <= hi);
    end
  endfunction

  // Pending network words; shared by the write strobe and the select
  function is_net_reg;
    input [11:0] a;
    begin
      is_net_reg = (a == `REG_NET_ADDR) ||
                   (a == `REG_NET_MASK) ||
                   (a == `REG_NET_PORT);
    end
  endfunction

  function [1:0] net_select;
    input [11:0] a;
    begin
      if (a == `REG_NET_ADDR)
        net_select = `NET_SEL_ADDR;
      else if (a == `REG_NET_MASK)
        net_select = `NET_SEL_MASK;
      else
        net_select = `NET_SEL_PORT;
    end
  endfunction

  // Count is even by contract; an odd last byte is not returned
  function [31:0] words_of;
    input [31:0] bytes;
    begin
      words_of = {1'b0, bytes[31:1]};
    end
  endfunction

  // Control and statistics
  reg         enable_q;
  reg         apply_q;
  reg  [15:0] accepts_q;
  reg  [15:0] drops_q;
  reg  [4:0]  reason_q;

  // Header capture
  reg         in_frame_q;
  reg  [5:0]  idx_q;
  reg  [15:0] marker_q;
  reg  [7:0]  version_q;
  reg  [7:0]  cmd_q;
  reg  [15:0] flags_q;
  reg  [31:0] count_q;
  reg  [15:0] addr_q;
  reg  [7:0]  family_q;
  reg  [31:0] raddr_q;
  reg  [15:0] rport_q;
  reg  [7:0]  hcrc_hi_q;
  reg  [31:0] src_addr_q;
  reg  [15:0] src_port_q;
  reg         dst_ok_q;

  wire [31:0] pend_addr;
  wire [31:0] pend_mask;
  wire [15:0] pend_port;
  wire [31:0] act_addr;
  wire [31:0] act_mask;
  wire [15:0] act_port;
  wire [15:0] crc_val;

  wire setup   = psel && !penable;
  wire wr_done = psel && penable && pready && pwrite;
  wire take    = rx_valid && rx_ready;
  wire start   = take && rx_sof && enable_q;
  wire body    = take && !rx_sof && in_frame_q;
  wire last    = body && (idx_q == `OFS_LAST);

  wire ctrl_wr = wr_done && (paddr == `REG_CTRL);
  wire net_wr  = wr_done && is_net_reg(paddr);
  wire [1:0] net_sel = net_select(paddr);

  net_settings_regs u_net (
    .clk         (clk),
    .rst_b       (rst_b),
    .wr_en       (net_wr),
    .wr_sel      (net_sel),
    .wdata       (pwdata),
    .apply       (apply_q),
    .pend_addr_q (pend_addr),
    .pend_mask_q (pend_mask),
    .pend_port_q (pend_port),
    .act_addr_q  (act_addr),
    .act_mask_q  (act_mask),
    .act_port_q  (act_port)
  );

  // Marker bytes are outside the checksum, so the CRC starts at byte 2
  header_crc16 u_crc (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (start),
    .en    (body && in_span(idx_q, `OFS_CRC_FIRST, `OFS_CRC_LAST)),
    .data  (rx_data),
    .crc_q (crc_val)
  );

  // Verdict on the final header byte
  wire ok_marker = (marker_q == `START_MARKER);
  wire ok_ver    = (version_q == `PROTO_REV);
  wire ok_cmd    = (cmd_q == `CMD_READ) && (family_q == `FAMILY_V4);
  wire ok_crc    = ({hcrc_hi_q, rx_data} == crc_val);
  wire [4:0] bad = {!dst_ok_q, !ok_cmd, !ok_crc, !ok_ver, !ok_marker};
  wire accept    = last && (bad == 5'h00);

  // Frame is ours if sent to our address, subnet broadcast, and our port
  wire dst_match = ((rx_dst_addr == act_addr) ||
                    (rx_dst_addr == (act_addr | ~act_mask))) &&
                   (rx_dst_port == act_port);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_frame_q <= 1'b0;
      idx_q      <= `OFS_MARKER;
      marker_q   <= 16'h0000;
      version_q  <= 8'h00;
      cmd_q      <= 8'h00;
      flags_q    <= 16'h0000;
      count_q    <= 32'h0000_0000;
      addr_q     <= 16'h0000;
      family_q   <= 8'h00;
      raddr_q    <= 32'h0000_0000;
      rport_q    <= 16'h0000;
      hcrc_hi_q  <= 8'h00;
      src_addr_q <= 32'h0000_0000;
      src_port_q <= 16'h0000;
      dst_ok_q   <= 1'b0;
    end else if (apply_q) begin
      // A device reset abandons any half-received header
      in_frame_q <= 1'b0;
      idx_q      <= `OFS_MARKER;
    end else if (start) begin
      in_frame_q <= 1'b1;
      idx_q      <= `OFS_MARKER + 6'h01;
      marker_q   <= {8'h00, rx_data};
      src_addr_q <= rx_src_addr;
      src_port_q <= rx_src_port;
      dst_ok_q   <= dst_match;
    end else if (body) begin
      idx_q <= idx_q + 6'h01;
      if (last)
        in_frame_q <= 1'b0;
      // Sub-command, status, spare, reserved and payload checksum
      // bytes fall through every branch below and are never stored
      if (in_span(idx_q, `OFS_MARKER, `OFS_MARKER + 6'h01))
        marker_q <= {marker_q[7:0], rx_data};
      else if (idx_q == `OFS_VERSION)
        version_q <= rx_data;
      else if (idx_q == `OFS_CMD)
        cmd_q <= rx_data;
      else if (in_span(idx_q, `OFS_FLAGS, `OFS_FLAGS + 6'h01))
        flags_q <= {flags_q[7:0], rx_data};
      else if (in_span(idx_q, `OFS_COUNT, `OFS_COUNT + 6'h03))
        count_q <= {count_q[23:0], rx_data};
      else if (idx_q == `OFS_ADDR_HI)
        addr_q[15:8] <= rx_data;
      else if (idx_q == `OFS_ADDR_LO)
        addr_q[7:0] <= rx_data;
      else if (idx_q == `OFS_FAMILY)
        family_q <= rx_data;
      else if (in_span(idx_q, `OFS_RADDR, `OFS_RADDR + 6'h03))
        raddr_q <= {raddr_q[23:0], rx_data};
      else if (in_span(idx_q, `OFS_RPORT, `OFS_RPORT + 6'h01))
        rport_q <= {rport_q[7:0], rx_data};
      else if (idx_q == `OFS_HCRC)
        hcrc_hi_q <= rx_data;
    end
  end

  // Zero callback fields send the answer back to the request's sender
  wire [31:0] reply_addr = (raddr_q == 32'h0000_0000) ?
                           src_addr_q : raddr_q;
  wire [15:0] reply_port = (rport_q == 16'h0000) ?
                           src_port_q : rport_q;

  // One outstanding read; the receive side stalls until it is taken
  wire rd_valid_d = accept || (rd_valid && !rd_ready);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid         <= 1'b0;
      rx_ready         <= 1'b1;
      rd_addr          <= 16'h0000;
      rd_count         <= 32'h0000_0000;
      rd_words         <= 32'h0000_0000;
      rd_skip_data_crc <= 1'b0;
      rd_reply_addr    <= 32'h0000_0000;
      rd_reply_port    <= 16'h0000;
      rd_data_ofs      <= `RESP_DATA_OFS;
    end else begin
      rd_valid <= rd_valid_d;
      rx_ready <= !rd_valid_d;
      if (accept) begin
        rd_addr          <= addr_q;
        rd_count         <= count_q;
        rd_words         <= words_of(count_q);
        rd_skip_data_crc <= flags_q[`FLAG_SKIP_BIT];
        rd_reply_addr    <= reply_addr;
        rd_reply_port    <= reply_port;
        rd_data_ofs      <= `RESP_DATA_OFS;
      end
    end
  end

  // Statistics
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accepts_q <= 16'h0000;
      drops_q   <= 16'h0000;
      reason_q  <= 5'h00;
    end else if (accept) begin
      accepts_q <= accepts_q + 16'h0001;
    end else if (last) begin
      drops_q  <= drops_q + 16'h0001;
      reason_q <= bad;
    end
  end

  // Control register; apply is a one-cycle device reset pulse
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= `CTRL_RESET;
      apply_q  <= 1'b0;
    end else begin
      apply_q <= ctrl_wr && pwdata[`CTRL_APPLY];
      if (ctrl_wr)
        enable_q <= pwdata[`CTRL_ENABLE];
    end
  end

  // Status: drop reason, header in progress, stream ready, read pending
  wire [31:0] status_word = {24'h00_0000, reason_q, in_frame_q,
                             rx_ready, rd_valid};

  // Read word and error for the addressed register; unmapped words error
  reg  [31:0] rdata_d;
  reg         rerr_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    if (paddr == `REG_CTRL)
      rdata_d = {31'h0000_0000, enable_q};
    else if (paddr == `REG_STATUS)
      rdata_d = status_word;
    else if (paddr == `REG_ACCEPTS)
      rdata_d = {16'h0000, accepts_q};
    else if (paddr == `REG_DROPS)
      rdata_d = {16'h0000, drops_q};
    else if (paddr == `REG_NET_ADDR)
      rdata_d = pend_addr;
    else if (paddr == `REG_NET_MASK)
      rdata_d = pend_mask;
    else if (paddr == `REG_NET_PORT)
      rdata_d = {16'h0000, pend_port};
    else if (paddr == `REG_ACT_ADDR)
      rdata_d = act_addr;
    else if (paddr == `REG_ACT_MASK)
      rdata_d = act_mask;
    else if (paddr == `REG_ACT_PORT)
      rdata_d = {16'h0000, act_port};
    else
      rerr_d = 1'b1;
  end

  // APB slave: data prepared in setup, answered in first access cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= rerr_d;
      prdata  <= rdata_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // udp_register_read_parser

/* verification/udp_register_read_parser_checker.sv */
// Port-level assertions for the register-read header parser
module parser_checker (
  input logic        clk,
  input logic        rst_b,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic        pready,
  input logic        pslverr,
  input logic        rx_valid,
  input logic        rx_ready,
  input logic        rd_valid,
  input logic        rd_ready,
  input logic [15:0] rd_addr,
  input logic [31:0] rd_reply_addr,
  input logic [31:0] rd_count,
  input logic [31:0] rd_words,
  input logic [7:0]  rd_data_ofs
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ofs; rd_data_ofs == 8'h40; endproperty
  a_ofs: assert property (p_ofs) else $error("data offset");
  property p_words; rd_valid |-> rd_words == {1'b0, rd_count[31:1]};
  endproperty
  a_words: assert property (p_words) else $error("word count");
  // Downstream may stall; the request must not drift meanwhile
  property p_hold; rd_valid && !rd_ready |=>
    rd_valid && $stable(rd_addr) && $stable(rd_reply_addr); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_free; rd_valid && rd_ready |=> !rd_valid && rx_ready;
  endproperty
  a_free: assert property (p_free) else $error("no release");
  property p_block; rd_valid |-> !rx_ready; endproperty
  a_block: assert property (p_block) else $error("took bytes");
  property p_rise; $rose(rd_valid) |-> $past(rx_valid && rx_ready);
  endproperty
  a_rise: assert property (p_rise) else $error("spurious read");
  property p_ack; psel && !penable |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("no pready");
  property p_err; pready && paddr > 12'h024 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no pslverr");
endmodule // parser_checker

bind udp_register_read_parser parser_checker chk_i (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rd_valid(rd_valid),
  .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_reply_addr(rd_reply_addr),
  .rd_count(rd_count), .rd_words(rd_words), .rd_data_ofs(rd_data_ofs));

/* verification/host_model.sv */
// Network host model: streams one 64-byte command header
module host_model (
  input  logic        clk,
  input  logic        rx_ready,
  output logic        rx_valid,
  output logic        rx_sof,
  output logic [7:0]  rx_data,
  output logic [31:0] rx_src_addr,
  output logic [15:0] rx_src_port,
  output logic [31:0] rx_dst_addr,
  output logic [15:0] rx_dst_port
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] f [64];
  assign rx_src_addr = 32'h0A000001;
  assign rx_src_port = 16'h1F40;
  assign rx_dst_addr = 32'hC0A8000A;
  assign rx_dst_port = 16'h2713;
  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = 8'h00;
  end
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) c = c[15] ? (c << 1) ^ 16'h1021 : c << 1;
    return c;
  endfunction
  task send(input logic bad);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 2; i < 62; i++) c = crc_step(c, f[i]);
    f[62] = c[15:8];
    f[63] = c[7:0] ^ {7'h00, bad};
    @(posedge clk);
    for (int i = 0; i < 64; i++) begin
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_data <= f[i];
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    // Released bus shows junk, not the last byte
    rx_data <= ~f[63];
  endtask
endmodule // host_model

/* verification/udp_register_read_parser_bench.sv */
// Self-checking bench for the register-read header parser
module udp_register_read_parser_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] mk; logic [7:0] ver, cmd, fam; logic bad, fl;
    logic [31:0] ra; logic [15:0] rp, ad; logic [31:0] cnt; logic ok;} row_t;
  row_t rows [7] = '{
    '{16'hA1EC, 8'h03, 8'h03, 8'h04, 0, 1, 0, 0, 16'h0102, 32'h8, 1},
    '{16'hA1EC, 8'h03, 8'h03, 8'h04, 0, 0, 32'hC0A80063, 16'h1234,
      16'hFFFE, 32'h6, 1},
    '{16'hA1ED, 8'h03, 8'h03, 8'h04, 0, 0, 0, 0, 16'h0010, 32'h2, 0},
    '{16'hA1EC, 8'h02, 8'h03, 8'h04, 0, 0, 0, 0, 16'h0010, 32'h2, 0},
    '{16'hA1EC, 8'h03, 8'h04, 8'h04, 0, 0, 0, 0, 16'h0010, 32'h2, 0},
    '{16'hA1EC, 8'h03, 8'h03, 8'h06, 0, 0, 0, 0, 16'h0010, 32'h2, 0},
    '{16'hA1EC, 8'h03, 8'h03, 8'h04, 1, 0, 0, 0, 16'h0010, 32'h2, 0}};
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rx_src_addr, rx_dst_addr, q;
  logic [31:0] rd_count, rd_words, rd_reply_addr;
  logic [15:0] rx_src_port, rx_dst_port, rd_addr, rd_reply_port;
  logic [7:0]  rx_data, rd_data_ofs;
  logic        pready, pslverr, rx_valid, rx_sof, rx_ready, rd_valid, e;
  logic        rd_ready = 0, rd_skip_data_crc;
  int          n_fail = 0, checks_done = 0;
  row_t        r;
  always #5 clk = ~clk;
  host_model host (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_data(rx_data), .rx_src_addr(rx_src_addr),
    .rx_src_port(rx_src_port), .rx_dst_addr(rx_dst_addr),
    .rx_dst_port(rx_dst_port));
  udp_register_read_parser dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data),
    .rx_src_addr(rx_src_addr), .rx_src_port(rx_src_port),
    .rx_dst_addr(rx_dst_addr), .rx_dst_port(rx_dst_port),
    .rx_ready(rx_ready), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_addr(rd_addr), .rd_count(rd_count), .rd_words(rd_words),
    .rd_skip_data_crc(rd_skip_data_crc), .rd_reply_addr(rd_reply_addr),
    .rd_reply_port(rd_reply_port), .rd_data_ofs(rd_data_ofs));
  task chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task frame(input row_t r);
    logic got;
    // Ignored bytes carry junk so they cannot sway acceptance
    for (int i = 0; i < 64; i++) host.f[i] = 8'(i * 5 + 3);
    {host.f[0], host.f[1]} = r.mk;
    host.f[2] = r.ver;
    host.f[3] = r.cmd;
    {host.f[6], host.f[7]} = {15'h0, r.fl};
    {host.f[8], host.f[9], host.f[10], host.f[11]} = r.cnt;
    {host.f[12], host.f[13]} = r.ad;
    host.f[16] = r.fam;
    {host.f[17], host.f[18], host.f[19], host.f[20]} = r.ra;
    {host.f[21], host.f[22]} = r.rp;
    host.send(r.bad);
    got = 0;
    for (int k = 0; k < 5 && !got; k++) begin
      @(posedge clk);
      got = rd_valid;
    end
    chk(got, r.ok);
    if (got) begin
      chk(rd_addr, r.ad);
      chk(rd_count, r.cnt);
      chk(rd_words, r.cnt >> 1);
      chk(rd_skip_data_crc, r.fl);
      chk(rd_reply_addr, r.ra != 0 ? r.ra : 32'h0A000001);
      chk(rd_reply_port, r.rp != 0 ? r.rp : 16'h1F40);
      repeat (3) @(posedge clk);
      chk(rd_valid, 1);
      rd_ready <= 1;
      @(posedge clk);
      rd_ready <= 0;
    end
  endtask
  task tally_and_finish;
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    chk({rd_valid, rx_ready}, 2'b01);
    apb(0, 12'h01C, 0);
    chk(q, 32'hC0A8000A);
    apb(0, 12'h020, 0);
    chk(q, 32'hFFFFFF00);
    apb(0, 12'h024, 0);
    chk(q[15:0], 16'd10003);
    for (int i = 0; i < 7; i++) frame(rows[i]);
    apb(0, 12'h008, 0);
    chk(q, 2);
    apb(0, 12'h00C, 0);
    chk(q, 5);
    apb(0, 12'h004, 0);
    chk(q, 32'h22);
    apb(1, 12'h100, 32'h5);
    chk(e, 1);
    apb(1, 12'h010, 32'hC0A80014);
    apb(0, 12'h01C, 0);
    chk(q, 32'hC0A8000A);
    apb(1, 12'h000, 32'h3);
    apb(0, 12'h01C, 0);
    chk(q, 32'hC0A80014);
    // Old address no longer listened to once new settings apply
    r = rows[0];
    r.ok = 0;
    frame(r);
    // Parser switched off: a header is ignored and not counted
    apb(1, 12'h000, 32'h0);
    apb(0, 12'h000, 0);
    chk(q, 0);
    frame(r);
    apb(0, 12'h00C, 0);
    chk(q, 6);
    // Hardware reset mid-run restores the factory settings
    @(posedge clk);
    rst_b <= 0;
    @(posedge clk);
    chk({pready, pslverr, rd_valid, rx_ready, rd_data_ofs}, 12'h140);
    rst_b <= 1;
    apb(0, 12'h01C, 0);
    chk(q, 32'hC0A8000A);
    apb(0, 12'h000, 0);
    chk(q, 1);
    tally_and_finish;
  end
endmodule // udp_register_read_parser_bench
